/* hdl/dapu_top.sv */
// Address pointer unit: pointer registers, banks and two address channels.
// Assumes decode, status bits and the internal data bus share mclk.
`timescale 1ns/100ps
`default_nettype none
module dapu_top(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [4:0] reg_idx,
	input wire dapu_pkg::dapu_word_t reg_wdata,
	output logic [dapu_pkg::OW-1:0] reg_rdata,
	input wire logic status2_wr,
	input wire logic [3:0] status2_bank,
	input wire logic bank_define_op,
	input wire logic [3:0] bank_imm,
	input wire logic bank_bit_wr,
	input wire logic [1:0] bank_bit_idx,
	input wire logic bank_bit_val,
	input wire logic [3:0] modulo_enable,
	input wire logic wide_step_enable,
	input wire logic acc_valid,
	input wire logic acc_dual,
	input wire logic acc_x_ptr1,
	input wire logic [1:0] acc_ptr,
	input wire logic acc_direct,
	input wire logic acc_write,
	input wire logic acc_step_hi,
	input wire logic acc_upd,
	output logic [dapu_pkg::AW-1:0] x_addr_bus,
	output logic [dapu_pkg::AW-1:0] y_addr_bus,
	output logic x_addr_vld,
	output logic y_addr_vld,
	output logic [3:0] bank_select
);
	import dapu_pkg::*;

	// Register storage; in the banked arrays the first index is the bank.
	dapu_word_t ptr_q [2][4];
	dapu_word_t sd_q [2][4];
	dapu_word_t sdx_q [2][2];
	dapu_word_t dp_q [2];
	dapu_word_t mc_q [2];
	logic [3:0] bank_q;
	logic [3:0] bank_d;
	logic [OW-1:0] rdata_q;
	logic [AW-1:0] xa_q;
	logic [AW-1:0] ya_q;
	logic xv_q;
	logic yv_q;

	// Channel pointer choice: channel one only serves dual accesses.
	wire [1:0] pn [2];
	wire bk [2];
	wire [15:0] cur [2];
	wire [15:0] nxt [2];
	wire [15:0] stp [2];
	assign pn[0] = acc_dual ? {1'b0, acc_x_ptr1} : acc_ptr;
	assign pn[1] = 2'h3;
	assign bk[0] = bank_q[pn[0]];
	assign bk[1] = bank_q[pn[1]];

	// Post-modification requests, one per channel.
	wire go0 = acc_valid & acc_upd & ~acc_direct;
	wire [1:0] go = {go0 & acc_dual, go0};

	// Register bus decode.
	wire in_ptr = reg_idx < RI_DPTR;
	wire in_dp = (reg_idx >= RI_DPTR) && (reg_idx < RI_SD);
	wire in_sd = (reg_idx >= RI_SD) && (reg_idx < RI_MC);
	wire in_mc = (reg_idx >= RI_MC) && (reg_idx < RI_END);
	wire [4:0] sd_off = reg_idx - RI_SD;
	wire rbk_p = bank_q[reg_idx[1:0]];
	wire rbk_s = bank_q[sd_off[1:0]];
	wire use_ext = in_sd & wide_step_enable & dapu_has_ext(sd_off[1:0]);

	// Readback selection; unmapped indices read as zero.
	wire [15:0] rd_val = in_ptr ? ptr_q[rbk_p][reg_idx[1:0]] :
		in_dp ? dp_q[reg_idx[0]] :
		use_ext ? sdx_q[rbk_s][sd_off[0]] :
		in_sd ? sd_q[rbk_s][sd_off[1:0]] :
		in_mc ? mc_q[reg_idx[0]] : RST_VAL;

	// One interface and one modifier pair per channel.
	dapu_upd_if ifc[2] (.mclk(mclk), .nrst(nrst));

	for (genvar c = 0; c < 2; c++) begin : g_ch
		assign ifc[c].ptr = ptr_q[bk[c]][pn[c]];
		assign ifc[c].idx = sd_q[bk[c]][pn[c]];
		assign ifc[c].ext = sdx_q[bk[c]][pn[c][0]];
		assign ifc[c].wide = wide_step_enable & dapu_has_ext(pn[c]);
		assign ifc[c].fsel = {acc_write, acc_step_hi};
		assign ifc[c].mcfg = mc_q[pn[c][1]];
		assign ifc[c].mod_en = modulo_enable[pn[c]];
		assign cur[c] = ifc[c].ptr;
		assign nxt[c] = ifc[c].nxt;
		assign stp[c] = ifc[c].step;

		dapu_step_sel u_stp (
			.u(ifc[c])
		);

		dapu_modulo u_mod (
			.u(ifc[c])
		);
	end

	// Pointer registers: modified value written back; a bus write wins.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < 4; i++) begin
					ptr_q[b][i] <= RST_VAL;
				end
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (go[c]) begin
					ptr_q[bk[c]][pn[c]] <= nxt[c];
				end
			end
			if (reg_wr && in_ptr) begin
				ptr_q[rbk_p][reg_idx[1:0]] <= reg_wdata;
			end
		end
	end

	// Step index and extension registers.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < 4; i++) begin
					sd_q[b][i] <= RST_VAL;
				end
				sdx_q[b][0] <= RST_VAL;
				sdx_q[b][1] <= RST_VAL;
			end
		end else if (reg_wr && use_ext) begin
			sdx_q[rbk_s][sd_off[0]] <= reg_wdata;
		end else if (reg_wr && in_sd) begin
			sd_q[rbk_s][sd_off[1:0]] <= reg_wdata;
		end
	end

	// Direct pointers and modulo configuration, never banked.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			dp_q[0] <= RST_VAL;
			dp_q[1] <= RST_VAL;
			mc_q[0] <= RST_VAL;
			mc_q[1] <= RST_VAL;
		end else if (reg_wr && in_dp) begin
			dp_q[reg_idx[0]] <= reg_wdata;
		end else if (reg_wr && in_mc) begin
			mc_q[reg_idx[0]] <= reg_wdata;
		end
	end

	// Bank bits: define op first, then single bit op, then status write.
	wire [3:0] bit_m = 4'h1 << bank_bit_idx;
	wire [3:0] bit_v = bank_bit_val ? (bank_q | bit_m) : (bank_q & ~bit_m);
	assign bank_d = bank_define_op ? bank_imm :
		bank_bit_wr ? bit_v :
		status2_wr ? status2_bank : bank_q;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			bank_q <= BANK_RST;
		end else begin
			bank_q <= bank_d;
		end
	end

	// Address source: direct pointer or channel zero, bit 15 steers.
	wire [15:0] src = acc_direct ? dp_q[acc_ptr[0]] : cur[0];
	wire x_hit = acc_valid & (acc_dual | ~src[SEL_BIT]);
	wire y_hit = acc_valid & (acc_dual | src[SEL_BIT]);
	wire [AW-1:0] ya_d = acc_dual ? cur[1][AW-1:0] : src[AW-1:0];

	// Address bus registers hold the last address between accesses.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			xv_q <= 1'b0;
			yv_q <= 1'b0;
			xa_q <= '0;
			ya_q <= '0;
		end else begin
			xv_q <= x_hit;
			yv_q <= y_hit;
			xa_q <= x_hit ? src[AW-1:0] : xa_q;
			ya_q <= y_hit ? ya_d : ya_q;
		end
	end

	// Read data register, zero-extended to the wide operand.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			rdata_q <= {8'h00, rd_val};
		end
	end

	assign reg_rdata = rdata_q;
	assign x_addr_bus = xa_q;
	assign y_addr_bus = ya_q;
	assign x_addr_vld = xv_q;
	assign y_addr_vld = yv_q;
	assign bank_select = bank_q;

	// Checks on the unit's own outputs and state.
	property p_dual_y;
		@(posedge mclk) disable iff (!nrst)
		(acc_valid && acc_dual) |=> y_addr_vld && x_addr_vld && (y_addr_bus == $past(cur[1][AW-1:0]));
	endproperty
	a_dual_y: assert property (p_dual_y) else $error("Dual access Y address not from pointer three.");

	property p_single_one;
		@(posedge mclk) disable iff (!nrst)
		(acc_valid && !acc_dual) |=> (x_addr_vld != y_addr_vld) && (y_addr_vld == $past(src[SEL_BIT]));
	endproperty
	a_single_one: assert property (p_single_one) else $error("Single access steered to wrong space.");

	property p_linear;
		@(posedge mclk) disable iff (!nrst)
		(go[0] && !ifc[0].mod_en && !reg_wr) |=> ptr_q[$past(bk[0])][$past(pn[0])] == $past(cur[0] + stp[0]);
	endproperty
	a_linear: assert property (p_linear) else $error("Linear post-modify wrong.");

	property p_bank_def;
		@(posedge mclk) disable iff (!nrst)
		bank_define_op |=> bank_select == $past(bank_imm);
	endproperty
	a_bank_def: assert property (p_bank_def) else $error("Bank define not loaded.");

	property p_bank_bit;
		@(posedge mclk) disable iff (!nrst)
		(bank_bit_wr && !bank_define_op) |=> bank_select[$past(bank_bit_idx)] == $past(bank_bit_val);
	endproperty
	a_bank_bit: assert property (p_bank_bit) else $error("Bank bit op not applied.");

	property p_rst;
		@(posedge mclk) disable iff (!nrst)
		$rose(nrst) |-> (bank_select == BANK_RST) && !x_addr_vld && (ptr_q[0][3] == RST_VAL) && (mc_q[1] == RST_VAL);
	endproperty
	a_rst: assert property (p_rst) else $error("State not cleared by reset.");

	property p_rd_ext;
		@(posedge mclk) disable iff (!nrst)
		(reg_wr && reg_idx == RI_MC) ##1 (reg_rd && !reg_wr && reg_idx == RI_MC)
			|=> reg_rdata == {8'h00, $past(reg_wdata, 2)};
	endproperty
	a_rd_ext: assert property (p_rd_ext) else $error("Readback not zero-extended write value.");

	// Pointer bits above the modulo window of channel zero, which an update must keep.
	wire [15:0] keep0 = ~dapu_mask(ifc[0].mcfg[MC_SZ_LO +: 3]);

	property p_dual_x;
		@(posedge mclk) disable iff (!nrst)
		(acc_valid && acc_dual && !acc_direct) |=> x_addr_bus == $past(cur[0][AW-1:0]);
	endproperty
	a_dual_x: assert property (p_dual_x) else $error("Dual access X address not from pointer zero or one.");

	property p_single_x;
		@(posedge mclk) disable iff (!nrst)
		(acc_valid && !acc_dual && !src[SEL_BIT]) |=> x_addr_bus == $past(src[AW-1:0]);
	endproperty
	a_single_x: assert property (p_single_x) else $error("Single X address not from pointer low bits.");

	property p_direct_keep;
		@(posedge mclk) disable iff (!nrst)
		(acc_valid && acc_direct && !reg_wr) |=> ptr_q[$past(bk[0])][$past(pn[0])] == $past(cur[0]);
	endproperty
	a_direct_keep: assert property (p_direct_keep) else $error("Direct access modified an indirect pointer.");

	property p_mod_upper;
		@(posedge mclk) disable iff (!nrst)
		(go[0] && ifc[0].mod_en && !reg_wr) |=> (ptr_q[$past(bk[0])][$past(pn[0])] & $past(keep0)) == $past(cur[0] & keep0);
	endproperty
	a_mod_upper: assert property (p_mod_upper) else $error("Modulo update touched bits above the window.");

	property p_status_wr;
		@(posedge mclk) disable iff (!nrst)
		(status2_wr && !bank_define_op && !bank_bit_wr) |=> bank_select == $past(status2_bank);
	endproperty
	a_status_wr: assert property (p_status_wr) else $error("Status two write did not load the banks.");

	property p_rd_zero;
		@(posedge mclk) disable iff (!nrst)
		reg_rd |=> reg_rdata[OW-1:DW] == 8'h00;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("Read data upper byte not zero.");

	property p_vld_idle;
		@(posedge mclk) disable iff (!nrst)
		!acc_valid |=> !x_addr_vld && !y_addr_vld;
	endproperty
	a_vld_idle: assert property (p_vld_idle) else $error("Address valid without an access.");

	property p_bus_hold;
		@(posedge mclk) disable iff (!nrst)
		!acc_valid |=> $stable(x_addr_bus) && $stable(y_addr_bus);
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("Address bus moved without an access.");
endmodule
`default_nettype wire

/* hdl/dapu_pkg.sv */
// Constants, types and helpers shared by the address pointer unit.
// Assumes one core clock; decode, status bits and registers share it.
// Function
// - Four indirect, two direct, four step index, two extension, two modulo registers.
// - First modulo config governs pointers zero/one, second governs two/three.
// - Status two bits 15..12 pick each pointer's bank, alternate on one.
// - Bank define loads all four bank bits, immediate bit n for pointer n.
// - A pointer's bank also switches its index and extension index.
// - Bank bits change by bank define, single bit op or status two write.
// - Single access: pointer bit 15 picks X or Y, bits 14..0 address.
// - Status zero bits 15..12 enable modulo update per pointer.
// - Dual access: pointer zero or one on X, pointer three on Y.
// - All registers read and write as 16 bits, zero-extended to 24.
// - Up to two 15-bit addresses per cycle, each post-modified.
// - Linear update is 16-bit two's complement addition of the step.
// - Ordinary steps are signed four bits, minus eight to plus seven.
// - Wide enable on pointer zero or three widens step to eight bits.
// - Reads use step bits 3..0 or 7..4, writes 11..8 or 15..12.
// - The instruction selects which of the four step fields applies.
// - Modulo config bits 12..10 give size, bits 9..0 upper boundary.
// - Modulo wraps low k bits at upper or lower boundary, else adds.
// - Current pointer drives the address; modified value written back.
// - With wide enable, index zero or three accesses the extension register.
package dapu_pkg;
	localparam int DW = 16;
	localparam int AW = 15;
	localparam int OW = 24;
	localparam int SEL_BIT = 15;
	localparam int MC_SZ_LO = 10;
	localparam int NIB = 4;
	localparam logic [4:0] RI_PTR = 5'h00;
	localparam logic [4:0] RI_DPTR = 5'h04;
	localparam logic [4:0] RI_SD = 5'h06;
	localparam logic [4:0] RI_MC = 5'h0A;
	localparam logic [4:0] RI_END = 5'h0C;
	localparam logic [15:0] RST_VAL = 16'h0000;
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [4:0] K_MAX = 5'h0A;
	localparam logic [4:0] K_OFS = 5'h02;
	localparam logic [4:0] K_FULL = 5'h10;

	typedef logic [15:0] dapu_word_t;

	// Low-bit mask for a modulo size code; code zero stands for 1024.
	function automatic dapu_word_t dapu_mask(input logic [2:0] code);
		logic [4:0] k;
		k = (code == 3'h0) ? K_MAX : ({2'h0, code} + K_OFS);
		return 16'hFFFF >> (K_FULL - k);
	endfunction

	// Sign-extends a four or eight bit step to a full word.
	function automatic dapu_word_t dapu_sext(input logic [7:0] v, input logic wide);
		return wide ? {{8{v[7]}}, v} : {{12{v[3]}}, v[3:0]};
	endfunction

	// Pointers zero and three own an extension index register.
	function automatic logic dapu_has_ext(input logic [1:0] n);
		return (n == 2'h0) || (n == 2'h3);
	endfunction
endpackage

/* hdl/dapu_upd_if.sv */
// Interface joining one pointer channel to its step and modulo logic.
// Assumes the top module drives pointer, index and configuration.
`timescale 1ns/100ps
`default_nettype none
interface dapu_upd_if(input wire logic mclk, input wire logic nrst);
	logic [15:0] ptr;
	logic [15:0] idx;
	logic [15:0] ext;
	logic [15:0] step;
	logic [15:0] mcfg;
	logic [15:0] nxt;
	logic [1:0] fsel;
	logic wide;
	logic mod_en;
	modport top(output ptr, idx, ext, fsel, wide, mcfg, mod_en, input nxt);
	modport stp(input mclk, nrst, idx, ext, fsel, wide, output step);
	modport mdl(input mclk, nrst, ptr, step, mcfg, mod_en, output nxt);
endinterface
`default_nettype wire

/* hdl/dapu_step_sel.sv */
// Step selection: picks one nibble field, with the extension nibble above it when wide, and sign-extends it.
// Assumes the top module has already chosen bank and extension register.
`timescale 1ns/100ps
`default_nettype none
module dapu_step_sel(
	dapu_upd_if.stp u
);
	import dapu_pkg::*;

	// Field select: bit 1 is write, bit 0 the high field of the pair.
	wire [3:0] nib_lo = u.idx[{u.fsel, 2'b00} +: NIB];
	wire [3:0] nib_hi = u.ext[{u.fsel, 2'b00} +: NIB];

	// The extension nibble becomes the upper half of a wide step.
	assign u.step = dapu_sext({nib_hi, nib_lo}, u.wide);

	property p_narrow_range;
		@(posedge u.mclk) disable iff (!u.nrst)
		!u.wide |-> ($signed(u.step) >= -16'sd8) && ($signed(u.step) <= 16'sd7) && (u.step[3:0] == nib_lo);
	endproperty
	a_narrow_range: assert property (p_narrow_range) else $error("Narrow step out of range.");

	property p_wide_step;
		@(posedge u.mclk) disable iff (!u.nrst)
		u.wide |-> (u.step[7:4] == nib_hi) && ($signed(u.step) >= -16'sd128) && ($signed(u.step) <= 16'sd127);
	endproperty
	a_wide_step: assert property (p_wide_step) else $error("Wide step not built from extension.");
endmodule
`default_nettype wire

/* hdl/dapu_modulo.sv */
// Post-modifier of one pointer: linear add or modulo wraparound.
// Assumes software keeps pointers and steps inside the modulo size.
`timescale 1ns/100ps
`default_nettype none
module dapu_modulo(
	dapu_upd_if.mdl u
);
	import dapu_pkg::*;

	// Size code gives the mask of the k low bits that may change.
	wire [15:0] mask = dapu_mask(u.mcfg[MC_SZ_LO +: 3]);
	wire [15:0] low = u.ptr & mask;
	wire [15:0] ub = {6'h00, u.mcfg[9:0]} & mask;
	wire pos = ~u.step[15] & (u.step != RST_VAL);
	wire neg = u.step[15];
	wire [15:0] lin = u.ptr + u.step;
	wire [15:0] wrap_lo = (pos && low == ub) ? RST_VAL : (neg && low == RST_VAL) ? ub : (lin & mask);

	// Upper bits hold still under modulo; the whole word moves otherwise.
	assign u.nxt = u.mod_en ? ((u.ptr & ~mask) | wrap_lo) : lin;

	property p_wrap_up;
		@(posedge u.mclk) disable iff (!u.nrst)
		(u.mod_en && pos && low == ub) |-> ((u.nxt & mask) == RST_VAL) && ((u.nxt & ~mask) == (u.ptr & ~mask));
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("Modulo upper wrap wrong.");

	property p_wrap_down;
		@(posedge u.mclk) disable iff (!u.nrst)
		(u.mod_en && neg && low == RST_VAL) |-> (u.nxt & mask) == ub;
	endproperty
	a_wrap_down: assert property (p_wrap_down) else $error("Modulo lower wrap wrong.");
endmodule
`default_nettype wire

/* test/dapu_mem_model.sv */
// Memory side model: latches each address the unit issues on X and Y.
// Assumes registered address outputs with one-cycle valid pulses.
`timescale 1ns/100ps
`default_nettype none
module dapu_mem_model(
	input wire logic mclk,
	input wire logic [14:0] x_addr_bus,
	input wire logic [14:0] y_addr_bus,
	input wire logic x_addr_vld,
	input wire logic y_addr_vld,
	output logic [14:0] mem_x,
	output logic [14:0] mem_y
);
	// Each bus is taken only in the cycle its valid is high.
	always_ff @(posedge mclk) begin
		if (x_addr_vld) begin
			mem_x <= x_addr_bus;
		end
		if (y_addr_vld) begin
			mem_y <= y_addr_bus;
		end
	end
endmodule
`default_nettype wire

/* test/test_dapu_top.sv */
// Testbench for the address pointer unit: register, access, bank and modulo sequences.
// Assumes the hand-over timing: strobes taken at an edge, answers one cycle later.
`timescale 1ns/100ps
`default_nettype none
module test_dapu_top;
	import dapu_pkg::*;
	logic mclk, nrst, reg_wr, reg_rd, status2_wr, bank_define_op, bank_bit_wr, bank_bit_val, wide_step_enable;
	logic acc_valid, acc_dual, acc_x_ptr1, acc_direct, acc_write, acc_step_hi, acc_upd, x_addr_vld, y_addr_vld;
	logic [4:0] reg_idx;
	dapu_word_t reg_wdata;
	logic [23:0] reg_rdata;
	logic [3:0] status2_bank, bank_imm, modulo_enable, bank_select;
	logic [1:0] bank_bit_idx, acc_ptr;
	logic [14:0] x_addr_bus, y_addr_bus, mem_x, mem_y;
	logic [15:0] p;
	logic [3:0] st [4];
	int n_errors = 0;
	int n_tests = 0;
	dapu_top uut(.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .status2_wr(status2_wr), .status2_bank(status2_bank),
		.bank_define_op(bank_define_op), .bank_imm(bank_imm), .bank_bit_wr(bank_bit_wr),
		.bank_bit_idx(bank_bit_idx), .bank_bit_val(bank_bit_val), .modulo_enable(modulo_enable),
		.wide_step_enable(wide_step_enable), .acc_valid(acc_valid), .acc_dual(acc_dual),
		.acc_x_ptr1(acc_x_ptr1), .acc_ptr(acc_ptr), .acc_direct(acc_direct), .acc_write(acc_write),
		.acc_step_hi(acc_step_hi), .acc_upd(acc_upd), .x_addr_bus(x_addr_bus), .y_addr_bus(y_addr_bus),
		.x_addr_vld(x_addr_vld), .y_addr_vld(y_addr_vld), .bank_select(bank_select));
	dapu_mem_model mem(.mclk(mclk), .x_addr_bus(x_addr_bus), .y_addr_bus(y_addr_bus),
		.x_addr_vld(x_addr_vld), .y_addr_vld(y_addr_vld), .mem_x(mem_x), .mem_y(mem_y));
	// Free-running core clock of 4 ns.
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Compares one value and counts the outcome.
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Writes one register with a single-cycle strobe.
	task automatic wr(input logic [4:0] i, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_idx <= i;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Reads one register and compares it one cycle after the strobe.
	task automatic rdc(input logic [4:0] i, input logic [23:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_idx <= i;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	// Issues one access; returns just after the edge that shows its addresses.
	task automatic acc(input logic d, x1, dr, input logic [1:0] pt, input logic w, hi, u);
		@(posedge mclk);
		acc_valid <= 1'b1;
		acc_dual <= d;
		acc_x_ptr1 <= x1;
		acc_direct <= dr;
		acc_ptr <= pt;
		acc_write <= w;
		acc_step_hi <= hi;
		acc_upd <= u;
		@(posedge mclk);
		acc_valid <= 1'b0;
		#1;
	endtask
	// Bank change: kind 0 define, 1 status write, 2 single bit (index v[1:0], value v[2]).
	task automatic bop(input int k, input logic [3:0] v);
		@(posedge mclk);
		bank_define_op <= (k == 0);
		status2_wr <= (k == 1);
		bank_bit_wr <= (k == 2);
		bank_imm <= v;
		status2_bank <= v;
		bank_bit_idx <= v[1:0];
		bank_bit_val <= v[2];
		@(posedge mclk);
		bank_define_op <= 1'b0;
		status2_wr <= 1'b0;
		bank_bit_wr <= 1'b0;
		#1;
	endtask
	// Cuts a hung run short.
	initial begin
		repeat (50000) @(posedge mclk);
		n_errors++;
		end_sim;
	end
	// Main sequence.
	initial begin
		{nrst, reg_wr, reg_rd, status2_wr, bank_define_op, bank_bit_wr, bank_bit_val, wide_step_enable} = '0;
		{acc_valid, acc_dual, acc_x_ptr1, acc_direct, acc_write, acc_step_hi, acc_upd} = '0;
		{reg_idx, reg_wdata, status2_bank, bank_imm, modulo_enable, bank_bit_idx, acc_ptr} = '0;
		st = '{4'h3, 4'hA, 4'h5, 4'h8};
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		for (int i = 0; i < 13; i++) rdc(i[4:0], 24'h0);
		for (int i = 0; i < 12; i++) begin
			wr(i[4:0], 16'h1230 + i[15:0]);
			rdc(i[4:0], {8'h00, 16'h1230 + i[15:0]});
		end
		wr(5'h0C, 16'hFFFF);
		rdc(5'h0C, 24'h0);
		// Back-to-back write and read of the first modulo register.
		@(posedge mclk) {reg_wr, reg_idx, reg_wdata} <= {1'b1, RI_MC, 16'h0C5A};
		@(posedge mclk) {reg_wr, reg_rd} <= 2'b01;
		@(posedge mclk) reg_rd <= 1'b0;
		#1 chk(reg_rdata, 24'h000C5A);
		// Pointer two walks through all four step fields.
		wr(5'h02, 16'h8100);
		wr(5'h08, 16'h85A3);
		p = 16'h8100;
		for (int f = 0; f < 4; f++) begin
			acc(1'b0, 1'b0, 1'b0, 2'h2, f[1], f[0], 1'b1);
			chk(y_addr_vld, 1'b1);
			chk(x_addr_vld, 1'b0);
			chk(y_addr_bus, p[14:0]);
			p = p + {{12{st[f][3]}}, st[f]};
			rdc(5'h02, {8'h00, p});
		end
		chk(mem_y, 15'h0102);
		acc(1'b0, 1'b0, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1);
		chk({x_addr_vld, x_addr_bus}, {1'b1, 15'h1235});
		// Dual access uses pointers zero or one on X and three on Y.
		wr(5'h00, 16'h8040);
		wr(5'h03, 16'h8060);
		acc(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1);
		chk({x_addr_vld, y_addr_vld, x_addr_bus}, {2'h3, 15'h0040});
		chk(y_addr_bus, 15'h0060);
		rdc(5'h00, 24'h008046);
		rdc(5'h03, 24'h008059);
		acc(1'b1, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
		chk(x_addr_bus, 15'h1231);
		// Wide steps through the extension index of pointer zero.
		@(posedge mclk) wide_step_enable <= 1'b1;
		wr(5'h06, 16'h000F);
		rdc(5'h06, 24'h00000F);
		wr(5'h00, 16'h0100);
		acc(1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1);
		rdc(5'h00, 24'h0000F6);
		acc(1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0, 1'b1);
		rdc(5'h01, 24'h001238);
		@(posedge mclk) wide_step_enable <= 1'b0;
		rdc(5'h06, 24'h001236);
		// Bank switching by all three methods.
		bop(0, 4'hE);
		chk(bank_select, 4'hE);
		rdc(5'h02, 24'h0);
		rdc(5'h08, 24'h0);
		rdc(5'h00, 24'h0000F6);
		wr(5'h02, 16'h0300);
		bop(1, 4'h0);
		chk(bank_select, 4'h0);
		rdc(5'h02, {8'h00, p});
		bop(2, 4'h6);
		chk(bank_select, 4'h4);
		rdc(5'h02, 24'h000300);
		bop(2, 4'h2);
		chk(bank_select, 4'h0);
		// Modulo size eight, upper bound seven, step one, on pointer zero.
		wr(5'h0A, 16'h0407);
		wr(5'h06, 16'h0001);
		wr(5'h00, 16'h0010);
		@(posedge mclk) modulo_enable <= 4'h1;
		p = 16'h0010;
		for (int n = 0; n < 9; n++) begin
			acc(1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1);
			chk(x_addr_bus, p[14:0]);
			p = (p[2:0] == 3'h7) ? {p[15:3], 3'h0} : p + 16'h1;
		end
		// Step minus two at the lower boundary reloads the upper one.
		wr(5'h0A, 16'h0405);
		chk(mem_x, 15'h0010);
		wr(5'h07, 16'h000E);
		wr(5'h01, 16'h2014);
		@(posedge mclk) modulo_enable <= 4'h2;
		acc(1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0, 1'b1);
		rdc(5'h01, 24'h002012);
		acc(1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0, 1'b1);
		rdc(5'h01, 24'h002010);
		acc(1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0, 1'b1);
		rdc(5'h01, 24'h002015);
		// Second configuration governs pointer two.
		wr(5'h0B, 16'h0403);
		wr(5'h08, 16'h0001);
		wr(5'h02, 16'h0003);
		@(posedge mclk) modulo_enable <= 4'h4;
		acc(1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b1);
		rdc(5'h02, 24'h0);
		end_sim;
	end
endmodule
`default_nettype wire
